// ==== rtl/lpc_consts.vh ====
`ifndef LPC_CONSTS_VH
`define LPC_CONSTS_VH
// ********************
// Register offsets
// ********************
`define LPC_REG_RSVD 4'h0
`define LPC_REG_CONFIG 4'h1
`define LPC_REG_IRQ 4'h2
`define LPC_REG_NEAR_LT 4'h3
`define LPC_REG_NEAR_HT 4'h4
`define LPC_REG_LTH1 4'h5
`define LPC_REG_LTH2 4'h6
`define LPC_REG_LTH3 4'h7
`define LPC_REG_NEAR_DATA 4'h8
`define LPC_REG_LDATA_LO 4'h9
`define LPC_REG_LDATA_HI 4'hA
// ********************
// Field positions
// ********************
`define LPC_CFG_PROX_EN 7
`define LPC_CFG_SLP_HI 6
`define LPC_CFG_SLP_LO 4
`define LPC_CFG_DRIVE 3
`define LPC_CFG_LIGHT_EN 2
`define LPC_CFG_RANGE 1
`define LPC_CFG_SPECTRUM 0
`define LPC_IRQ_PFLAG 7
`define LPC_IRQ_PPRST_HI 6
`define LPC_IRQ_PPRST_LO 5
`define LPC_IRQ_LFLAG 3
`define LPC_IRQ_LPRST_HI 2
`define LPC_IRQ_LPRST_LO 1
`define LPC_IRQ_COMBINE 0
// ********************
// Reset values
// ********************
`define LPC_RST_CONFIG 8'h00
`define LPC_RST_IRQ 8'h00
`define LPC_RST_NEAR_LT 8'h00
`define LPC_RST_NEAR_HT 8'hFF
`define LPC_RST_LTH1 8'h00
`define LPC_RST_LTH2 8'hF0
`define LPC_RST_LTH3 8'hFF
// ********************
// Bus address, upper six bits
// ********************
`define LPC_I2C_ADDR_HI 6'h22
// ********************
// Timing
// ********************
`define LPC_CLK_PERIOD_NS 5
`define LPC_PROX_CONV_NS 540000
`define LPC_LED_ON_NS 100000
`define LPC_LIGHT_CONV_NS 100000000
`define LPC_SLEEP_BASE_NS 12500000
// Sleep time in multiples of the base
`define LPC_SLP_000 7'h40
`define LPC_SLP_001 7'h20
`define LPC_SLP_010 7'h10
`define LPC_SLP_011 7'h08
`define LPC_SLP_100 7'h06
`define LPC_SLP_101 7'h04
`define LPC_SLP_110 7'h01
`define LPC_SLP_111 7'h00
// Persistence targets
`define LPC_PRST_00 5'h01
`define LPC_PRST_01 5'h04
`define LPC_PRST_10 5'h08
`define LPC_PRST_11 5'h10
`endif

// ==== rtl/lpc_persist.v ====
`timescale 1ns/1ps
`include "lpc_consts.vh"
module lpc_persist (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Conversion outcome
    input wire sample,
    input wire trip,
    input wire [1:0] sel,
    // Event
    output reg event_hit
);
reg [4:0] count;
reg [4:0] target;
wire [4:0] count_inc;

assign count_inc = count + 5'h01;

// ********************
// Target count
// ********************
always @* begin
    case (sel)
        2'b00: target = `LPC_PRST_00;
        2'b01: target = `LPC_PRST_01;
        2'b10: target = `LPC_PRST_10;
        default: target = `LPC_PRST_11;
    endcase
end

// ********************
// Consecutive trip counter
// ********************
always @(posedge clk) begin
    if (!rst_n) begin
        count <= 5'h00;
        event_hit <= 1'b0;
    end else begin
        event_hit <= 1'b0;
        if (sample) begin
            if (trip) begin
                if (count_inc >= target) begin
                    event_hit <= 1'b1;
                    count <= 5'h00;
                end else begin
                    count <= count_inc;
                end
            end else begin
                count <= 5'h00;
            end
        end
    end
end
endmodule // lpc_persist

// ==== rtl/lpc_regs.v ====
// Notes on behaviour
// - Prox enable, data 0.54ms later
// - Sleep code sets LED pulse gap
// - Drive bit: 110mA or 220mA
// - Light enable, result every 100ms
// - Range bit: low or high lux
// - Spectrum bit: visible or infrared
// - Prox flag sticky, cleared by zero
// - Prox persistence 1/4/8/16 trips
// - Light flag sticky, cleared by zero
// - Light persistence 1/4/8/16
// - Combine bit: either or both flags
// - Prox low threshold, reset 0x00
// - Prox high threshold, reset 0xFF
// - Light low threshold LSB, reset 0x00
// - Light threshold rest in next registers
// - Bus address 100010 plus select pin
`timescale 1ns/1ps
`include "lpc_consts.vh"
module lpc_regs #(
    parameter [27:0] PROX_CONV_CYC = `LPC_PROX_CONV_NS / `LPC_CLK_PERIOD_NS,
    parameter [27:0] LED_ON_CYC = `LPC_LED_ON_NS / `LPC_CLK_PERIOD_NS,
    parameter [27:0] LIGHT_CONV_CYC = `LPC_LIGHT_CONV_NS / `LPC_CLK_PERIOD_NS,
    parameter [27:0] SLEEP_BASE_CYC = `LPC_SLEEP_BASE_NS / `LPC_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Serial bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire addr_select_pin,
    // Converter levels
    input wire [7:0] prox_adc,
    input wire [11:0] light_adc,
    // Sensor controls
    output reg led_driver_pin,
    output wire led_drive_strength,
    output wire light_sense_enable,
    output wire light_range_sel,
    output wire light_spectrum_sel,
    // Interrupt pin
    output reg int_n
);
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_ADDR = 3'h1;
localparam [2:0] S_AACK = 3'h2;
localparam [2:0] S_WDATA = 3'h3;
localparam [2:0] S_WACK = 3'h4;
localparam [2:0] S_RDATA = 3'h5;
localparam [2:0] S_RACK = 3'h6;
localparam [1:0] P_IDLE = 2'h0;
localparam [1:0] P_CONV = 2'h1;
localparam [1:0] P_SLEEP = 2'h2;

reg scl_m;
reg scl_s;
reg scl_d;
reg sda_m;
reg sda_s;
reg sda_d;
reg addr_m;
reg addr_s;
reg [2:0] state;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg [7:0] tx;
reg [3:0] ptr;
reg ptr_done;
reg rw;
reg nack;
reg wr_stb;
reg [3:0] wr_addr;
reg [7:0] wr_data;
reg [7:0] sensor_config;
reg [7:0] irq_control;
reg [7:0] near_low_threshold;
reg [7:0] near_high_threshold;
reg [7:0] light_low_threshold_lsb;
reg [7:0] light_threshold_mid;
reg [7:0] light_threshold_msb;
reg [7:0] near_result;
reg [11:0] light_result;
reg [7:0] rdata;
reg [1:0] pstate;
reg [27:0] pcnt;
reg [27:0] lcnt;
reg prox_done;
reg light_done;
reg prox_near;
reg [6:0] slp_mul;
wire scl_rise;
wire scl_fall;
wire start_cond;
wire stop_cond;
wire [34:0] slp_prod;
wire [27:0] slp_len;
wire [11:0] light_low_threshold;
wire [11:0] light_high_threshold;
wire prox_en;
wire prox_trip;
wire light_trip;
wire prox_event;
wire light_event;
wire flag_wr;
wire next_pflag;
wire next_lflag;

// ********************
// Pin synchronisers
// ********************
always @(posedge clk) begin
    if (!rst_n) begin
        scl_m <= 1'b1;
        scl_s <= 1'b1;
        scl_d <= 1'b1;
        sda_m <= 1'b1;
        sda_s <= 1'b1;
        sda_d <= 1'b1;
        addr_m <= 1'b0;
        addr_s <= 1'b0;
    end else begin
        scl_m <= scl_in;
        scl_s <= scl_m;
        scl_d <= scl_s;
        sda_m <= sda_in;
        sda_s <= sda_m;
        sda_d <= sda_s;
        addr_m <= addr_select_pin;
        addr_s <= addr_m;
    end
end

assign scl_rise = scl_s & ~scl_d;
assign scl_fall = ~scl_s & scl_d;
assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

// ********************
// Read data select
// ********************
always @* begin
    if (ptr == `LPC_REG_CONFIG) begin
        rdata = sensor_config;
    end else if (ptr == `LPC_REG_IRQ) begin
        rdata = irq_control;
    end else if (ptr == `LPC_REG_NEAR_LT) begin
        rdata = near_low_threshold;
    end else if (ptr == `LPC_REG_NEAR_HT) begin
        rdata = near_high_threshold;
    end else if (ptr == `LPC_REG_LTH1) begin
        rdata = light_low_threshold_lsb;
    end else if (ptr == `LPC_REG_LTH2) begin
        rdata = light_threshold_mid;
    end else if (ptr == `LPC_REG_LTH3) begin
        rdata = light_threshold_msb;
    end else if (ptr == `LPC_REG_NEAR_DATA) begin
        rdata = near_result;
    end else if (ptr == `LPC_REG_LDATA_LO) begin
        rdata = light_result[7:0];
    end else if (ptr == `LPC_REG_LDATA_HI) begin
        rdata = {4'h0, light_result[11:8]};
    end else begin
        rdata = 8'h00;
    end
end

// ********************
// Serial slave
// ********************
always @(posedge clk) begin
    if (!rst_n) begin
        state <= S_IDLE;
        bit_cnt <= 4'h0;
        shreg <= 8'h00;
        tx <= 8'h00;
        ptr <= 4'h0;
        ptr_done <= 1'b0;
        rw <= 1'b0;
        nack <= 1'b0;
        wr_stb <= 1'b0;
        wr_addr <= 4'h0;
        wr_data <= 8'h00;
        sda_out <= 1'b0;
        sda_oe_n <= 1'b1;
    end else begin
        wr_stb <= 1'b0;
        if (start_cond) begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            ptr_done <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (stop_cond) begin
            state <= S_IDLE;
            sda_oe_n <= 1'b1;
        end else if (scl_rise) begin
            if (state == S_ADDR || state == S_WDATA) begin
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (state == S_RACK) begin
                nack <= sda_s;
            end
        end else if (scl_fall) begin
            case (state)
                S_ADDR: begin
                    if (bit_cnt == 4'h8) begin
                        if (shreg[7:1] == {`LPC_I2C_ADDR_HI, addr_s}) begin
                            rw <= shreg[0];
                            sda_oe_n <= 1'b0;
                            state <= S_AACK;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    bit_cnt <= 4'h0;
                    if (rw) begin
                        tx <= rdata;
                        sda_oe_n <= rdata[7];
                        bit_cnt <= 4'h1;
                        state <= S_RDATA;
                    end else begin
                        sda_oe_n <= 1'b1;
                        state <= S_WDATA;
                    end
                end
                S_WDATA: begin
                    if (bit_cnt == 4'h8) begin
                        sda_oe_n <= 1'b0;
                        state <= S_WACK;
                        if (!ptr_done) begin
                            ptr <= shreg[3:0];
                            ptr_done <= 1'b1;
                        end else begin
                            wr_stb <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shreg;
                            ptr <= ptr + 4'h1;
                        end
                    end
                end
                S_WACK: begin
                    sda_oe_n <= 1'b1;
                    bit_cnt <= 4'h0;
                    state <= S_WDATA;
                end
                S_RDATA: begin
                    if (bit_cnt == 4'h8) begin
                        sda_oe_n <= 1'b1;
                        ptr <= ptr + 4'h1;
                        state <= S_RACK;
                    end else begin
                        sda_oe_n <= tx[6];
                        tx <= {tx[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                S_RACK: begin
                    if (nack) begin
                        state <= S_IDLE;
                    end else begin
                        tx <= rdata;
                        sda_oe_n <= rdata[7];
                        bit_cnt <= 4'h1;
                        state <= S_RDATA;
                    end
                end
                default: begin
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end
end

// ********************
// Register file
// ********************
assign flag_wr = wr_stb && (wr_addr == `LPC_REG_IRQ);
assign next_pflag = prox_event |
    (irq_control[`LPC_IRQ_PFLAG] & ~(flag_wr & ~wr_data[`LPC_IRQ_PFLAG]));
assign next_lflag = light_event |
    (irq_control[`LPC_IRQ_LFLAG] & ~(flag_wr & ~wr_data[`LPC_IRQ_LFLAG]));

always @(posedge clk) begin
    if (!rst_n) begin
        sensor_config <= `LPC_RST_CONFIG;
        irq_control <= `LPC_RST_IRQ;
        near_low_threshold <= `LPC_RST_NEAR_LT;
        near_high_threshold <= `LPC_RST_NEAR_HT;
        light_low_threshold_lsb <= `LPC_RST_LTH1;
        light_threshold_mid <= `LPC_RST_LTH2;
        light_threshold_msb <= `LPC_RST_LTH3;
    end else begin
        irq_control[`LPC_IRQ_PFLAG] <= next_pflag;
        irq_control[`LPC_IRQ_LFLAG] <= next_lflag;
        if (wr_stb) begin
            if (wr_addr == `LPC_REG_CONFIG) begin
                sensor_config <= wr_data;
            end else if (wr_addr == `LPC_REG_IRQ) begin
                irq_control[6:4] <= wr_data[6:4];
                irq_control[2:0] <= wr_data[2:0];
            end else if (wr_addr == `LPC_REG_NEAR_LT) begin
                near_low_threshold <= wr_data;
            end else if (wr_addr == `LPC_REG_NEAR_HT) begin
                near_high_threshold <= wr_data;
            end else if (wr_addr == `LPC_REG_LTH1) begin
                light_low_threshold_lsb <= wr_data;
            end else if (wr_addr == `LPC_REG_LTH2) begin
                light_threshold_mid <= wr_data;
            end else if (wr_addr == `LPC_REG_LTH3) begin
                light_threshold_msb <= wr_data;
            end
        end
    end
end

assign prox_en = sensor_config[`LPC_CFG_PROX_EN];
assign led_drive_strength = sensor_config[`LPC_CFG_DRIVE];
assign light_sense_enable = sensor_config[`LPC_CFG_LIGHT_EN];
assign light_range_sel = sensor_config[`LPC_CFG_RANGE];
assign light_spectrum_sel = sensor_config[`LPC_CFG_SPECTRUM];
assign light_low_threshold = {light_threshold_mid[3:0], light_low_threshold_lsb};
assign light_high_threshold = {light_threshold_msb, light_threshold_mid[7:4]};

// ********************
// Proximity timing
// ********************
always @* begin
    case (sensor_config[`LPC_CFG_SLP_HI:`LPC_CFG_SLP_LO])
        3'b000: slp_mul = `LPC_SLP_000;
        3'b001: slp_mul = `LPC_SLP_001;
        3'b010: slp_mul = `LPC_SLP_010;
        3'b011: slp_mul = `LPC_SLP_011;
        3'b100: slp_mul = `LPC_SLP_100;
        3'b101: slp_mul = `LPC_SLP_101;
        3'b110: slp_mul = `LPC_SLP_110;
        default: slp_mul = `LPC_SLP_111;
    endcase
end

assign slp_prod = SLEEP_BASE_CYC * slp_mul;
assign slp_len = slp_prod[27:0];

always @(posedge clk) begin
    if (!rst_n) begin
        pstate <= P_IDLE;
        pcnt <= 28'h0;
        led_driver_pin <= 1'b0;
        prox_done <= 1'b0;
        near_result <= 8'h00;
    end else begin
        prox_done <= 1'b0;
        if (!prox_en) begin
            pstate <= P_IDLE;
            pcnt <= 28'h0;
            led_driver_pin <= 1'b0;
        end else begin
            case (pstate)
                P_IDLE: begin
                    pstate <= P_CONV;
                    pcnt <= 28'h0;
                    led_driver_pin <= 1'b1;
                end
                P_CONV: begin
                    pcnt <= pcnt + 28'h1;
                    if (pcnt == LED_ON_CYC - 28'h1) begin
                        led_driver_pin <= 1'b0;
                    end
                    if (pcnt == PROX_CONV_CYC - 28'h1) begin
                        near_result <= prox_adc;
                        prox_done <= 1'b1;
                        pcnt <= 28'h0;
                        if (slp_len == 28'h0) begin
                            led_driver_pin <= 1'b1;
                        end else begin
                            pstate <= P_SLEEP;
                        end
                    end
                end
                P_SLEEP: begin
                    pcnt <= pcnt + 28'h1;
                    if (pcnt + 28'h1 >= slp_len) begin
                        pcnt <= 28'h0;
                        led_driver_pin <= 1'b1;
                        pstate <= P_CONV;
                    end
                end
                default: begin
                    pstate <= P_IDLE;
                end
            endcase
        end
    end
end

// ********************
// Light timing
// ********************
always @(posedge clk) begin
    if (!rst_n) begin
        lcnt <= 28'h0;
        light_done <= 1'b0;
        light_result <= 12'h000;
    end else begin
        light_done <= 1'b0;
        if (!light_sense_enable) begin
            lcnt <= 28'h0;
        end else if (lcnt == LIGHT_CONV_CYC - 28'h1) begin
            lcnt <= 28'h0;
            light_result <= light_adc;
            light_done <= 1'b1;
        end else begin
            lcnt <= lcnt + 28'h1;
        end
    end
end

// ********************
// Threshold compare
// ********************
assign prox_trip = (near_result > near_high_threshold) & ~prox_near;
assign light_trip = (light_result < light_low_threshold) |
    (light_result > light_high_threshold);

always @(posedge clk) begin
    if (!rst_n) begin
        prox_near <= 1'b0;
    end else if (prox_event) begin
        prox_near <= 1'b1;
    end else if (prox_done && near_result < near_low_threshold) begin
        prox_near <= 1'b0;
    end
end

lpc_persist u_prox_persist (
    .clk(clk),
    .rst_n(rst_n),
    .sample(prox_done),
    .trip(prox_trip),
    .sel(irq_control[`LPC_IRQ_PPRST_HI:`LPC_IRQ_PPRST_LO]),
    .event_hit(prox_event)
);

lpc_persist u_light_persist (
    .clk(clk),
    .rst_n(rst_n),
    .sample(light_done),
    .trip(light_trip),
    .sel(irq_control[`LPC_IRQ_LPRST_HI:`LPC_IRQ_LPRST_LO]),
    .event_hit(light_event)
);

// ********************
// Interrupt pin
// ********************
always @(posedge clk) begin
    if (!rst_n) begin
        int_n <= 1'b1;
    end else if (irq_control[`LPC_IRQ_COMBINE]) begin
        int_n <= ~(irq_control[`LPC_IRQ_PFLAG] & irq_control[`LPC_IRQ_LFLAG]);
    end else begin
        int_n <= ~(irq_control[`LPC_IRQ_PFLAG] | irq_control[`LPC_IRQ_LFLAG]);
    end
end
endmodule // lpc_regs

// ==== verification/lpc_regs_checker.sv ====
`timescale 1ns/1ps
module lpc_regs_checker #(
    parameter [27:0] PROX_CONV_CYC = 28'h1A5E0,
    parameter [27:0] LED_ON_CYC = 28'h4E20
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Bus pins
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe_n,
    // Sensor pins
    input wire led_driver_pin,
    input wire led_drive_strength,
    input wire light_sense_enable,
    input wire light_range_sel,
    input wire light_spectrum_sel,
    input wire int_n
);
    // ********************
    // Helper counters
    // ********************
    logic [27:0] led_cnt;
    logic [27:0] gap;
    wire [3:0] cfg_pins = {led_drive_strength, light_sense_enable, light_range_sel,
                           light_spectrum_sel};
    always @(posedge clk) begin
        if (!rst_n) begin
            led_cnt <= 28'h0;
            gap <= 28'hFFFFFFF;
        end else begin
            led_cnt <= led_driver_pin ? led_cnt + 28'h1 : 28'h0;
            if ($rose(led_driver_pin)) gap <= 28'h1;
            else if (gap != 28'hFFFFFFF) gap <= gap + 28'h1;
        end
    end
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_ack_soon;
        ##[0:8] !sda_oe_n;
    endsequence
    sequence s_int_held;
        !int_n [*8];
    endsequence
    a_reset_idle: assert property ($rose(rst_n) |->
        sda_oe_n && int_n && !led_driver_pin && cfg_pins == 4'h0)
        else $error("not idle after reset");
    a_sda_out_low: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_ack_release: assert property ($fell(sda_oe_n) |-> ##[1:150] sda_oe_n)
        else $error("data line held too long");
    a_bus_idle_free: assert property (scl_in [*8] |-> sda_oe_n)
        else $error("data held on idle bus");
    a_cfg_acked: assert property (!$stable(cfg_pins) |-> s_ack_soon)
        else $error("config change without write");
    a_led_width: assert property ($fell(led_driver_pin) |-> led_cnt == LED_ON_CYC)
        else $error("led pulse width wrong");
    a_led_gap: assert property ($rose(led_driver_pin) |-> gap >= PROX_CONV_CYC)
        else $error("led pulses too close");
    a_int_hold: assert property ($fell(int_n) |=> s_int_held)
        else $error("interrupt pin not held");
endmodule // lpc_regs_checker
bind lpc_regs lpc_regs_checker #(
    .PROX_CONV_CYC(PROX_CONV_CYC),
    .LED_ON_CYC(LED_ON_CYC)
) u_checker (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .led_driver_pin(led_driver_pin), .led_drive_strength(led_drive_strength),
    .light_sense_enable(light_sense_enable), .light_range_sel(light_range_sel),
    .light_spectrum_sel(light_spectrum_sel), .int_n(int_n)
);

// ==== verification/lpc_host.sv ====
`timescale 1ns/1ps
module lpc_host (
    // Bus lines
    output logic scl,
    output logic sda_drv,
    input wire sda_pin
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // ********************
    // Bus cycles
    // ********************
    task automatic xfer(input logic b, output logic s);
        scl = 1'b0;
        #12 sda_drv = b;
        #12 scl = 1'b1;
        s = sda_pin;
        #24;
    endtask
    task automatic start;
        scl = 1'b0;
        #12 sda_drv = 1'b1;
        #12 scl = 1'b1;
        #12 sda_drv = 1'b0;
        #12;
    endtask
    task automatic stop;
        scl = 1'b0;
        #12 sda_drv = 1'b0;
        #12 scl = 1'b1;
        #12 sda_drv = 1'b1;
        #24;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, s);
        ack = ~s;
    endtask
    task automatic write(input logic [6:0] a, input logic [3:0] p, input logic [7:0] d,
                         output logic ok);
        logic k1, k2, k3;
        if (p == 4'h2) d[4] = 1'b0;
        start();
        put_byte({a, 1'b0}, k1);
        put_byte({4'h0, p}, k2);
        put_byte(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    task automatic read(input logic [6:0] a, input logic [3:0] p, output logic [7:0] d,
                        output logic ok);
        logic k1, k2, k3, s;
        start();
        put_byte({a, 1'b0}, k1);
        put_byte({4'h0, p}, k2);
        start();
        put_byte({a, 1'b1}, k3);
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(1'b1, s);
        stop();
        ok = k1 & k2 & k3;
    endtask
endmodule // lpc_host

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tb;
    localparam int PCONV = 40;
    localparam int LCONV = 100;
    localparam int SBASE = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic addr_select_pin = 1'b0;
    logic [7:0] prox_adc = 8'h00;
    logic [11:0] light_adc = 12'h000;
    logic [6:0] dev_addr = 7'h44;
    wire scl, sda_drv, sda_out, sda_oe_n, led_driver_pin, led_drive_strength;
    wire light_sense_enable, light_range_sel, light_spectrum_sel, int_n;
    wire sda_pin = sda_drv & (sda_oe_n | sda_out);
    wire [3:0] cfg_pins = {led_drive_strength, light_sense_enable, light_range_sel,
                           light_spectrum_sel};
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    lpc_host host (.scl(scl), .sda_drv(sda_drv), .sda_pin(sda_pin));
    lpc_regs #(
        .PROX_CONV_CYC(28'h28), .LED_ON_CYC(28'h8), .LIGHT_CONV_CYC(28'h64),
        .SLEEP_BASE_CYC(28'hA)
    ) DUT (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_pin), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .addr_select_pin(addr_select_pin), .prox_adc(prox_adc),
        .light_adc(light_adc), .led_driver_pin(led_driver_pin),
        .led_drive_strength(led_drive_strength), .light_sense_enable(light_sense_enable),
        .light_range_sel(light_range_sel), .light_spectrum_sel(light_spectrum_sel),
        .int_n(int_n)
    );
    // ********************
    // Shared tasks
    // ********************
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic wr(input logic [3:0] p, input logic [7:0] d);
        logic ok;
        host.write(dev_addr, p, d, ok);
        `CHK("write ack", 1'b1, ok)
    endtask
    task automatic rd(input logic [3:0] p, output logic [7:0] d);
        logic ok;
        host.read(dev_addr, p, d, ok);
        `CHK("read ack", 1'b1, ok)
    endtask
    task automatic to_rise(output int c);
        for (c = 0; led_driver_pin !== 1'b0 && c < 3000; c++) @(negedge clk);
        for (; led_driver_pin !== 1'b1 && c < 3000; c++) @(negedge clk);
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_regs;
        logic [7:0] rst_tab [0:10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hF0,
                                       8'hFF, 8'h00, 8'h00, 8'h00};
        logic [7:0] cfg [0:1] = '{8'h0B, 8'h04};
        logic [7:0] d;
        for (int i = 1; i <= 10; i++) begin
            rd(i[3:0], d);
            `CHK("reset value", rst_tab[i], d)
        end
        rd(4'hB, d);
        `CHK("unmapped read", 8'h00, d)
        wr(4'h8, 8'h77);
        rd(4'h8, d);
        `CHK("result read only", 8'h00, d)
        for (int i = 0; i < 2; i++) begin
            wr(4'h1, cfg[i]);
            rd(4'h1, d);
            `CHK("config readback", cfg[i], d)
            `CHK("config pins", cfg[i][3:0], cfg_pins)
        end
        wr(4'h1, 8'h00);
        for (int i = 3; i <= 7; i++) begin
            wr(i[3:0], 8'hA0 + i[7:0]);
            rd(i[3:0], d);
            `CHK("threshold readback", 8'hA0 + i[7:0], d)
        end
    endtask
    task automatic t_addr;
        logic ok;
        logic [7:0] d;
        @(posedge clk);
        addr_select_pin <= 1'b1;
        repeat (4) @(posedge clk);
        dev_addr = 7'h45;
        wr(4'h3, 8'h3C);
        host.write(7'h44, 4'h3, 8'hC3, ok);
        `CHK("foreign address ack", 1'b0, ok)
        rd(4'h3, d);
        `CHK("foreign write ignored", 8'h3C, d)
    endtask
    task automatic t_sleep;
        int mult [0:7] = '{64, 32, 16, 8, 6, 4, 1, 0};
        int base, p7, c;
        for (int i = 7; i >= 0; i--) begin
            wr(4'h1, {1'b1, i[2:0], 4'h0});
            to_rise(c);
            to_rise(c);
            if (i == 7) p7 = c;
            else begin
                if (i == 6) base = c;
                `CHK("sleep length", (mult[i] - 1) * SBASE, c - base)
            end
        end
        `CHK("conversion period", 1'b1, p7 >= PCONV && p7 <= PCONV + 4)
        wr(4'h1, 8'h00);
    endtask
    task automatic t_light;
        int need [0:3] = '{1, 4, 8, 16};
        int c;
        logic [7:0] d;
        wr(4'h5, 8'h00);
        wr(4'h6, 8'h01);
        wr(4'h7, 8'h20);
        for (int n = 0; n < 4; n++) begin
            @(posedge clk);
            light_adc <= 12'h050;
            wr(4'h2, {5'h00, n[1:0], 1'b0});
            wr(4'h1, 8'h04);
            for (c = 0; int_n !== 1'b0 && c < 3000; c++) @(negedge clk);
            c -= need[n] * LCONV;
            `CHK("light persistence", 1'b1, c > -60 && c < 60)
            @(posedge clk);
            light_adc <= 12'h150;
            repeat (2 * LCONV) @(posedge clk);
            wr(4'h1, 8'h00);
            rd(4'h2, d);
            `CHK("light flag", 1'b1, d[3])
            wr(4'h2, 8'h08);
            `CHK("flag kept on writing one", 1'b0, int_n)
            wr(4'h2, 8'h00);
            `CHK("pin released", 1'b1, int_n)
        end
    endtask
    task automatic t_combine;
        logic [7:0] d;
        @(posedge clk);
        prox_adc <= 8'h90;
        light_adc <= 12'h150;
        wr(4'h3, 8'h10);
        wr(4'h4, 8'h80);
        wr(4'h2, 8'h01);
        wr(4'h1, 8'h84);
        repeat (3 * LCONV) @(posedge clk);
        wr(4'h1, 8'h04);
        `CHK("both needed", 1'b1, int_n)
        rd(4'h2, d);
        `CHK("near flag only", 2'b10, {d[7], d[3]})
        @(posedge clk);
        light_adc <= 12'h250;
        repeat (3 * LCONV) @(posedge clk);
        `CHK("both set", 1'b0, int_n)
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h09);
        `CHK("near flag cleared", 1'b1, int_n)
        wr(4'h2, 8'h08);
        `CHK("either set", 1'b0, int_n)
        rd(4'h2, d);
        `CHK("flags after clear", 8'h08, d)
        wr(4'h2, 8'h00);
        `CHK("pin released", 1'b1, int_n)
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_addr();
        t_sleep();
        t_light();
        t_combine();
        give_verdict();
    end
endmodule // tb
